// >>> hw/rpa_patch_match.sv
// program patch unit: two fetch address matchers and their registers
`timescale 1ns/1ps
module rpa_patch_match
  import rpa_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic [rpa_pkg::RPA_ADDR_W-1:0] FETCH_ADDR_IN,
  input wire logic FETCH_VALID_IN,
  input wire logic [15:0] REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire rpa_pkg::rpa_size_t REG_SIZE_IN,
  input wire logic [2:0] REG_BIT_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [15:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  output logic BRANCH_REQ_OUT,
  output logic [rpa_pkg::RPA_ADDR_W-1:0] BRANCH_ADDR_OUT
);
  import rpa_pkg::*;

  rpa_chan_if chan0 ();
  rpa_chan_if chan1 ();

  logic enable0;
  logic enable1;
  logic hit0;
  logic hit1;
  logic hit_clear0;
  logic hit_clear1;
  logic ctrl_sel;
  logic ctrl_byte_wr;
  logic ctrl_bit_wr;
  logic word_wr;
  logic any_match;
  logic [7:0] ctrl_view;
  logic [15:0] next_rdata;

  // address decode of register writes
  assign ctrl_sel = (REG_ADDR_IN == RPA_CONTROL);
  assign ctrl_byte_wr = REG_WR_IN && ctrl_sel && (REG_SIZE_IN == RPA_SZ_BYTE);
  assign ctrl_bit_wr = REG_WR_IN && ctrl_sel && (REG_SIZE_IN == RPA_SZ_BIT);
  assign word_wr = REG_WR_IN && (REG_SIZE_IN == RPA_SZ_WORD);

  // target loads: only word writes at the low address are taken
  // word only
  assign chan0.load = word_wr && (REG_ADDR_IN == RPA_TARGET0_LO);
  assign chan1.load = word_wr && (REG_ADDR_IN == RPA_TARGET1_LO);
  assign chan0.wdata = REG_WDATA_IN;
  assign chan1.wdata = REG_WDATA_IN;
  assign chan0.enable = enable0;
  assign chan1.enable = enable1;

  rpa_channel u_chan0 (
    .clk_in(SYS_CLK_IN),
    .reset_n_in(RESET_N_IN),
    .fetch_addr_in(FETCH_ADDR_IN),
    .fetch_valid_in(FETCH_VALID_IN),
    .ch(chan0.chan)
  );

  rpa_channel u_chan1 (
    .clk_in(SYS_CLK_IN),
    .reset_n_in(RESET_N_IN),
    .fetch_addr_in(FETCH_ADDR_IN),
    .fetch_valid_in(FETCH_VALID_IN),
    .ch(chan1.chan)
  );

  // enable bits, written by byte or by single bit
  // control reset
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      enable0 <= RPA_CONTROL_RESET[RPA_EN0_BIT];
      enable1 <= RPA_CONTROL_RESET[RPA_EN1_BIT];
    end
    else if (ctrl_byte_wr)
    begin
      enable0 <= REG_WDATA_IN[RPA_EN0_BIT];
      enable1 <= REG_WDATA_IN[RPA_EN1_BIT];
    end
    else if (ctrl_bit_wr)
    begin
      if (REG_BIT_IN == RPA_EN0_BIT)
        enable0 <= REG_WDATA_IN[0];
      if (REG_BIT_IN == RPA_EN1_BIT)
        enable1 <= REG_WDATA_IN[0];
    end
  end

  // software may only clear a hit bit; a written 1 changes nothing
  // clear only
  always_comb
  begin
    hit_clear0 = 1'b0;
    hit_clear1 = 1'b0;
    if (ctrl_byte_wr)
    begin
      hit_clear0 = !REG_WDATA_IN[RPA_HIT0_BIT];
      hit_clear1 = !REG_WDATA_IN[RPA_HIT1_BIT];
    end
    else if (ctrl_bit_wr)
    begin
      hit_clear0 = (REG_BIT_IN == RPA_HIT0_BIT) && !REG_WDATA_IN[0];
      hit_clear1 = (REG_BIT_IN == RPA_HIT1_BIT) && !REG_WDATA_IN[0];
    end
  end

  // hit flags set on the same edge as the branch request
  // flag with request
  rpa_hit_flag u_hit0 (
    .clk_in(SYS_CLK_IN),
    .reset_n_in(RESET_N_IN),
    .set_in(chan0.match),
    .clear_in(hit_clear0),
    .flag_out(hit0)
  );

  rpa_hit_flag u_hit1 (
    .clk_in(SYS_CLK_IN),
    .reset_n_in(RESET_N_IN),
    .set_in(chan1.match),
    .clear_in(hit_clear1),
    .flag_out(hit1)
  );

  // one request for any number of matching channels
  // single request
  assign any_match = chan0.match || chan1.match;

  // branch request towards the fetch unit
  // branch request
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      BRANCH_REQ_OUT <= 1'b0;
    else
      BRANCH_REQ_OUT <= any_match;
  end

  // fixed patch destination, held in a flop
  // fixed vector
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      BRANCH_ADDR_OUT <= RPA_PATCH_VECTOR;
    else
      BRANCH_ADDR_OUT <= RPA_PATCH_VECTOR;
  end

  // control register view; unused bits read zero
  // hit readback
  always_comb
  begin
    ctrl_view = RPA_CONTROL_RESET;
    ctrl_view[RPA_HIT0_BIT] = hit0;
    ctrl_view[RPA_EN0_BIT] = enable0;
    ctrl_view[RPA_HIT1_BIT] = hit1;
    ctrl_view[RPA_EN1_BIT] = enable1;
  end

  // read data select by address and size
  always_comb
  begin
    next_rdata = RPA_UNMAPPED_DATA;
    unique case (REG_ADDR_IN)
      RPA_TARGET0_LO:
        next_rdata = (REG_SIZE_IN == RPA_SZ_WORD) ? chan0.target
                                                  : {8'h00, chan0.target[7:0]};
      RPA_TARGET0_HI:
        next_rdata = {8'h00, chan0.target[15:8]};
      RPA_TARGET1_LO:
        next_rdata = (REG_SIZE_IN == RPA_SZ_WORD) ? chan1.target
                                                  : {8'h00, chan1.target[7:0]};
      RPA_TARGET1_HI:
        next_rdata = {8'h00, chan1.target[15:8]};
      RPA_CONTROL:
        next_rdata = (REG_SIZE_IN == RPA_SZ_BIT) ? {15'h0000, ctrl_view[REG_BIT_IN]}
                                                 : {8'h00, ctrl_view};
      default:
        next_rdata = RPA_UNMAPPED_DATA;
    endcase
  end

  // registered read answer, one cycle after the request
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      REG_RDATA_OUT <= RPA_UNMAPPED_DATA;
    else if (REG_RD_IN)
      REG_RDATA_OUT <= next_rdata;
  end

  // read valid strobe
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      REG_RVALID_OUT <= 1'b0;
    else
      REG_RVALID_OUT <= REG_RD_IN;
  end

  // a fetch hitting an enabled channel 0 target
  sequence hit0_fetch_s;
    FETCH_VALID_IN && enable0 && (FETCH_ADDR_IN == chan0.target);
  endsequence

  // a fetch hitting an enabled channel 1 target
  sequence hit1_fetch_s;
    FETCH_VALID_IN && enable1 && (FETCH_ADDR_IN == chan1.target);
  endsequence

  // request and flag rise together after a channel 0 hit
  hit0_branch_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    hit0_fetch_s |=> (BRANCH_REQ_OUT && hit0))
    else $error("channel 0 hit without request and flag");

  // request and flag rise together after a channel 1 hit
  hit1_branch_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    hit1_fetch_s |=> (BRANCH_REQ_OUT && hit1))
    else $error("channel 1 hit without request and flag");

  // no request without an enabled match the cycle before
  no_stray_req_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    BRANCH_REQ_OUT |-> $past(any_match))
    else $error("branch request without an enabled match");

  // both channels hitting give one request and both flags
  dual_hit_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (hit0_fetch_s and hit1_fetch_s) |=> (BRANCH_REQ_OUT && hit0 && hit1))
    else $error("dual hit did not set both flags");

  // destination always the fixed patch vector
  vector_fixed_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    BRANCH_REQ_OUT |-> (BRANCH_ADDR_OUT == RPA_PATCH_VECTOR))
    else $error("branch destination is not the patch vector");

  // a control byte write never sets hit flag 0
  hit_write_one_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (ctrl_byte_wr && !hit0 && !chan0.match) |=> !hit0)
    else $error("software write set a hit flag");

  // byte write updates both enables exactly
  ctrl_byte_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    ctrl_byte_wr |=> (enable0 == $past(REG_WDATA_IN[RPA_EN0_BIT]))
                     && (enable1 == $past(REG_WDATA_IN[RPA_EN1_BIT])))
    else $error("control byte write not taken");

  // single-bit write to enable 1 moves only that enable
  ctrl_bit_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (ctrl_bit_wr && (REG_BIT_IN == RPA_EN1_BIT))
      |=> (enable1 == $past(REG_WDATA_IN[0])) && (enable0 == $past(enable0)))
    else $error("control bit write not taken");

  // a written zero clears hit flag 0 when no hit lands with it
  hit0_clear_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (hit_clear0 && !chan0.match) |=> !hit0)
    else $error("software clear of hit flag 0 lost");

  // a written zero clears hit flag 1 when no hit lands with it
  hit1_clear_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (hit_clear1 && !chan1.match) |=> !hit1)
    else $error("software clear of hit flag 1 lost");

  // non-word write leaves the channel 1 target unchanged
  target1_byte_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (REG_WR_IN && (REG_SIZE_IN != RPA_SZ_WORD)) |=> $stable(chan1.target))
    else $error("channel 1 target changed by a non-word write");

  // no match, no request in the next cycle
  req_drop_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    !any_match |=> !BRANCH_REQ_OUT)
    else $error("branch request held without a match");

  // non-word write leaves the channel 0 target unchanged
  target_byte_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (REG_WR_IN && (REG_SIZE_IN != RPA_SZ_WORD)) |=> $stable(chan0.target))
    else $error("target changed by a non-word write");

  // control byte read answer follows its request by one cycle
  read_answer_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RESET_N_IN)
    (REG_RD_IN && ctrl_sel && (REG_SIZE_IN == RPA_SZ_BYTE))
      |=> REG_RVALID_OUT && (REG_RDATA_OUT[7:0] == $past(ctrl_view)))
    else $error("control readback wrong");
endmodule : rpa_patch_match

// >>> hw/rpa_pkg.sv
// package of constants and types for the program patch address matcher
package rpa_pkg;
  localparam int unsigned RPA_CHANNELS = 2;
  localparam int unsigned RPA_ADDR_W = 16;
  localparam int unsigned RPA_CTRL_W = 8;
  // register byte addresses
  localparam logic [15:0] RPA_TARGET0_LO = 16'hff38;
  localparam logic [15:0] RPA_TARGET0_HI = 16'hff39;
  localparam logic [15:0] RPA_TARGET1_LO = 16'hff3a;
  localparam logic [15:0] RPA_TARGET1_HI = 16'hff3b;
  localparam logic [15:0] RPA_CONTROL = 16'hff8a;
  // reset values
  localparam logic [15:0] RPA_TARGET_RESET = 16'h0000;
  localparam logic [7:0] RPA_CONTROL_RESET = 8'h00;
  localparam logic RPA_FLAG_RESET = 1'b0;
  // control field positions
  localparam logic [2:0] RPA_HIT0_BIT = 3'h0;
  localparam logic [2:0] RPA_EN0_BIT = 3'h1;
  localparam logic [2:0] RPA_HIT1_BIT = 3'h2;
  localparam logic [2:0] RPA_EN1_BIT = 3'h3;
  // fixed branch destination of a patch hit
  localparam logic [15:0] RPA_PATCH_VECTOR = 16'hf7fd;
  // read data of an unmapped address
  localparam logic [15:0] RPA_UNMAPPED_DATA = 16'h0000;
  // access size of a register request
  typedef enum logic [1:0] {
    RPA_SZ_BYTE = 2'h0,
    RPA_SZ_WORD = 2'h1,
    RPA_SZ_BIT = 2'h3
  } rpa_size_t;
endpackage : rpa_pkg

// >>> hw/rpa_chan_if.sv
// interface between the top control logic and one patch channel
`timescale 1ns/1ps
interface rpa_chan_if;
  logic [15:0] wdata;
  logic load;
  logic enable;
  logic match;
  logic [15:0] target;
  modport ctrl (output wdata, output load, output enable, input match, input target);
  modport chan (input wdata, input load, input enable, output match, output target);
endinterface : rpa_chan_if

// >>> hw/rpa_channel.sv
// one patch channel: target address register and fetch comparator
`timescale 1ns/1ps
module rpa_channel
  import rpa_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [rpa_pkg::RPA_ADDR_W-1:0] fetch_addr_in,
  input wire logic fetch_valid_in,
  rpa_chan_if.chan ch
);
  logic [RPA_ADDR_W-1:0] target;

  // word load of the target address, cleared by reset
  // target reset
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      target <= RPA_TARGET_RESET;
    else if (ch.load)
      target <= ch.wdata;
  end

  assign ch.target = target;

  // continuous compare, gated by the channel enable
  // compare fetch
  assign ch.match = ch.enable && fetch_valid_in && (fetch_addr_in == target);

  // word load lands whole in the target register
  target_load_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ch.load |=> (target == $past(ch.wdata)))
    else $error("target register did not take the written word");

  // a disabled channel never reports a match
  match_gate_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !ch.enable |-> !ch.match)
    else $error("match seen on a disabled channel");
endmodule : rpa_channel

// >>> hw/rpa_hit_flag.sv
// sticky hit flag: hardware sets, software clears, set wins
`timescale 1ns/1ps
module rpa_hit_flag
  import rpa_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);
  // set has priority over a same-cycle software clear
  // sticky flag
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      flag_out <= RPA_FLAG_RESET;
    else if (set_in)
      flag_out <= 1'b1;
    else if (clear_in)
      flag_out <= 1'b0;
  end

  // without a clear request the flag never falls
  flag_sticky_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (flag_out && !clear_in) |=> flag_out)
    else $error("hit flag dropped without a software clear");

  // a set always wins, even against a clear
  set_wins_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    set_in |=> flag_out)
    else $error("hit flag not set after a hit");
endmodule : rpa_hit_flag

// >>> verification/rpa_cpu_model.sv
// cpu fetch side model: issues opcode fetches and follows patch branches
`timescale 1ns/1ps
module rpa_cpu_model
  import rpa_pkg::*;
(
  input wire logic clk_in,
  input wire logic branch_req_in,
  input wire logic [15:0] branch_addr_in,
  output logic [15:0] fetch_addr_out,
  output logic fetch_valid_out
);
  int hits = 0;
  logic [15:0] pc = 16'h0000;

  // idle fetch bus at time zero
  initial
  begin
    fetch_valid_out = 1'b0;
    fetch_addr_out = 16'hffff;
  end

  task automatic fetch(input logic [15:0] a);
    @(posedge clk_in);
    fetch_addr_out <= a;
    fetch_valid_out <= 1'b1;
    @(posedge clk_in);
    fetch_valid_out <= 1'b0;
    fetch_addr_out <= ~a;  // released bus shows no stale address
  endtask : fetch

  always @(posedge clk_in)
  begin
    if (branch_req_in === 1'b1)
    begin
      hits <= hits + 1;
      pc <= branch_addr_in;
    end
    else if (fetch_valid_out)
      pc <= fetch_addr_out;  // pc follows the issued fetch
  end
endmodule : rpa_cpu_model

// >>> verification/rpa_patch_match_tb.sv
// self-checking bench for the program patch address matcher
`timescale 1ns/1ps
module rpa_patch_match_tb;
  import rpa_pkg::*;
  `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] fetch_addr;
  logic fetch_valid;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  rpa_size_t reg_size = RPA_SZ_BYTE;
  logic [2:0] reg_bit = 3'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] rdata;
  logic rvalid;
  logic br_req;
  logic [15:0] br_addr;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  rpa_patch_match u_rpa_patch_match (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
    .FETCH_ADDR_IN(fetch_addr), .FETCH_VALID_IN(fetch_valid), .REG_ADDR_IN(reg_addr),
    .REG_WDATA_IN(reg_wdata), .REG_SIZE_IN(reg_size), .REG_BIT_IN(reg_bit),
    .REG_WR_IN(reg_wr), .REG_RD_IN(reg_rd), .REG_RDATA_OUT(rdata),
    .REG_RVALID_OUT(rvalid), .BRANCH_REQ_OUT(br_req), .BRANCH_ADDR_OUT(br_addr));

  rpa_cpu_model u_rpa_cpu_model (.clk_in(clk), .branch_req_in(br_req),
    .branch_addr_in(br_addr), .fetch_addr_out(fetch_addr), .fetch_valid_out(fetch_valid));

  // 100 ns clock
  initial
  begin
    forever #50 clk = ~clk;
  end

  // counts and verdict, then end of run
  task automatic summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      summarize();
    end
  end

  // one register write strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input rpa_size_t sz,
                    input logic [2:0] b);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_size <= sz;
    reg_bit <= b;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // one register read, answer judged one cycle later
  task automatic rd(input logic [15:0] a, input rpa_size_t sz, input logic [2:0] b,
                    input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_size <= sz;
    reg_bit <= b;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rdata", e, rdata)
  endtask : rd

  // one opcode fetch, branch request judged in the answer cycle
  task automatic fet(input logic [15:0] a, input logic e);
    u_rpa_cpu_model.fetch(a);
    #1;
    `CHK("branch_req", e, br_req)
    @(posedge clk);
    #1;
    `CHK("branch_req_end", 1'b0, br_req)
  endtask : fet

  // reset values of all registers and the vector
  task automatic t_reset;
    rd(RPA_TARGET0_LO, RPA_SZ_WORD, 3'h0, 16'h0000);
    rd(RPA_TARGET1_LO, RPA_SZ_WORD, 3'h0, 16'h0000);
    rd(RPA_CONTROL, RPA_SZ_BYTE, 3'h0, 16'h0000);
    `CHK("branch_addr", 16'hf7fd, br_addr)
  endtask : t_reset

  // word loads stick, a byte write to target 0 is refused
  task automatic t_load;
    wr(RPA_TARGET0_LO, 16'h1000, RPA_SZ_WORD, 3'h0);
    wr(RPA_TARGET0_LO, 16'h00ff, RPA_SZ_BYTE, 3'h0);
    rd(RPA_TARGET0_LO, RPA_SZ_WORD, 3'h0, 16'h1000);
    rd(RPA_TARGET0_HI, RPA_SZ_BYTE, 3'h0, 16'h0010);
    wr(RPA_TARGET1_LO, 16'h2000, RPA_SZ_WORD, 3'h0);
    rd(RPA_TARGET1_LO, RPA_SZ_WORD, 3'h0, 16'h2000);
  endtask : t_load

  // channel 0: disabled silence, then enabled hit
  task automatic t_match;
    fet(16'h1000, 1'b0);
    wr(RPA_CONTROL, 16'h0001, RPA_SZ_BIT, RPA_EN0_BIT);
    fet(16'h1000, 1'b1);
    `CHK("cpu_pc", 16'hf7fd, u_rpa_cpu_model.pc)
    rd(RPA_CONTROL, RPA_SZ_BYTE, 3'h0, 16'h0003);
    fet(16'h2000, 1'b0);
    rd(RPA_CONTROL, RPA_SZ_BIT, RPA_HIT1_BIT, 16'h0000);
    rd(RPA_CONTROL, RPA_SZ_BIT, RPA_HIT0_BIT, 16'h0001);
  endtask : t_match

  // flags stay set across other writes; software clears with zeros only
  task automatic t_sticky;
    fet(16'h3000, 1'b0);
    rd(RPA_CONTROL, RPA_SZ_BYTE, 3'h0, 16'h0003);
    wr(RPA_CONTROL, 16'h0001, RPA_SZ_BIT, RPA_EN1_BIT);
    rd(RPA_CONTROL, RPA_SZ_BYTE, 3'h0, 16'h000b);
    fet(16'h2000, 1'b1);
    rd(RPA_CONTROL, RPA_SZ_BYTE, 3'h0, 16'h000f);
    wr(RPA_CONTROL, 16'h000a, RPA_SZ_BYTE, 3'h0);
    rd(RPA_CONTROL, RPA_SZ_BYTE, 3'h0, 16'h000a);
  endtask : t_sticky

  // both channels on one address: one request, two flags
  task automatic t_both;
    int h;
    wr(RPA_CONTROL, 16'h0000, RPA_SZ_BYTE, 3'h0);
    wr(RPA_TARGET1_LO, 16'h1000, RPA_SZ_WORD, 3'h0);
    wr(RPA_CONTROL, 16'h000a, RPA_SZ_BYTE, 3'h0);
    h = u_rpa_cpu_model.hits;
    fet(16'h1000, 1'b1);
    `CHK("branch_count", h + 1, u_rpa_cpu_model.hits)
    rd(RPA_CONTROL, RPA_SZ_BYTE, 3'h0, 16'h000f);
  endtask : t_both

  // reset, then scenarios in turn
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_load();
    t_match();
    t_sticky();
    t_both();
    summarize();
  end
endmodule : rpa_patch_match_tb
